// >>> arss_mem_model.sv
// Behavioural external memory that answers select-strobe reads
`timescale 1ns/1ps
`default_nettype none
module arss_mem_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [arss_pkg::BANKS-1:0] chip_select_n,
    input wire logic output_enable_n,
    input wire logic [arss_pkg::ADDR_W-1:0] ext_addr_lines,
    input wire logic [arss_pkg::BA_W-1:0] low_order_addr_lines,
    output logic [arss_pkg::DATA_W-1:0] read_value_lines,
    output logic wait_input
);
    logic selected;
    logic [arss_pkg::DATA_W-1:0] last_r;
    int strobe_age;

    // Word only while selected; else inverted last output, so idle lines toggle and repeat the stale word every other cycle
    assign selected = (chip_select_n != 4'hF) && !output_enable_n;
    assign read_value_lines = selected ? ({ext_addr_lines[13:0], low_order_addr_lines} ^ 16'hA5C3)
        : ~last_r;

    // Track the strobe age; a slow device holds wait for its first 12 strobe cycles
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            last_r <= 16'h0000;
            strobe_age <= 0;
            wait_input <= 1'b0;
        end else begin
            last_r <= read_value_lines;
            strobe_age <= selected ? strobe_age + 1 : 0;
            wait_input <= slow && selected && (strobe_age < 12);
        end
    end
endmodule
`default_nettype wire

// >>> arss_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module arss_pin_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    arss_pkg::arss_sync_t sync_r;
    arss_pkg::arss_sync_t sync_nxt;

    // First stage feeds only the second; output moves when stages two and three agree
    always_comb begin
        sync_nxt = sync_r;
        sync_nxt.s1 = pin;
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
        if (sync_r.s2 == sync_r.s3) begin
            sync_nxt.q = sync_r.s3;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_r <= arss_pkg::SYNC_RST;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign level = sync_r.q;
endmodule
`default_nettype wire

// >>> arss_pkg.sv
// Shared constants and types of the select-strobe asynchronous read sequencer
//
// Summary of operation
// - Write strobe stays high during reads
// - Start read only when highest priority
// - Repeat access cycles until request complete
// - Turnaround cycles come from config field
// - Read after read: no turnaround
// - Read after write, field zero: one cycle
// - Recheck priority after turnaround, else abandon
// - Load setup, strobe, hold at setup
// - Address lines valid from setup start
// - Byte enables valid from setup start
// - Chip select and output enable fall
// - Strobe end: release strobes, capture data
// - Select-strobe bit: select only during strobe
// - Narrow device: back to setup, no reload
package arss_pkg;
    localparam int ADDR_W = 22;
    localparam int BA_W = 2;
    localparam int DATA_W = 16;
    localparam int BE_W = 2;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int TA_W = 2;
    localparam int SETUP_W = 4;
    localparam int STROBE_W = 6;
    localparam int HOLD_W = 3;
    localparam int IDX_W = 2;
    localparam int CNT_W = 6;
    localparam int PHASE_W = 8;

    typedef logic [CNT_W-1:0] arss_cnt_t;
    typedef logic [BANKS-1:0] arss_cs_t;
    typedef logic [PHASE_W-1:0] arss_phase_t;

    localparam arss_cs_t CS_IDLE = 4'hF;
    localparam arss_cs_t CS_ONE = 4'h1;
    localparam logic [BE_W-1:0] BE_IDLE_N = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_IDLE = 22'h0;
    localparam logic [BA_W-1:0] BA_IDLE = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0;
    localparam logic [TA_W-1:0] TA_NONE = 2'h0;
    localparam logic [TA_W-1:0] TA_AFTER_WR_MIN = 2'h1;
    localparam arss_phase_t PHASE_MAX = 8'hFF;

    typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_SETUP, ST_STROBE, ST_HOLD} arss_st_t;

    // Per-chip-select configuration, held steady by software
    typedef struct packed {
        logic ss;
        logic wait_en;
        logic [TA_W-1:0] turnaround_cycles;
        logic [SETUP_W-1:0] r_setup;
        logic [STROBE_W-1:0] r_strobe;
        logic [HOLD_W-1:0] r_hold;
    } arss_cfg_t;

    // Read request; last_idx is the number of access cycles minus one
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BA_W-1:0] ba;
        logic [BANK_W-1:0] bank;
        logic [BE_W-1:0] be;
        logic [IDX_W-1:0] last_idx;
    } arss_req_t;

    typedef struct packed {
        logic [SETUP_W-1:0] setup;
        logic [STROBE_W-1:0] strobe;
        logic [HOLD_W-1:0] hold;
    } arss_tim_t;

    // Answer to the requester; all flags are one-cycle pulses
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic valid;
        logic start;
        logic done;
        logic abort;
    } arss_rsp_t;

    typedef struct packed {
        arss_st_t st;
        arss_cnt_t cnt;
        logic [TA_W-1:0] turn_len;
        logic [IDX_W-1:0] idx;
        arss_req_t req;
        arss_tim_t tim;
        logic ss;
        logic prev_read;
        logic prev_write;
        arss_cs_t cs_n;
        logic oe_n;
        logic addr_valid;
        logic [ADDR_W-1:0] addr;
        logic [BA_W-1:0] ba;
        logic [BE_W-1:0] be_n;
        arss_rsp_t rsp;
    } arss_state_t;

    localparam arss_state_t STATE_RST = '{
        st: ST_IDLE, cnt: '0, turn_len: TA_NONE, idx: '0, req: '0, tim: '0,
        ss: 1'b0, prev_read: 1'b0, prev_write: 1'b0, cs_n: CS_IDLE, oe_n: 1'b1,
        addr_valid: 1'b0, addr: ADDR_IDLE, ba: BA_IDLE, be_n: BE_IDLE_N,
        rsp: '{data: DATA_RST, valid: 1'b0, start: 1'b0, done: 1'b0, abort: 1'b0}
    };

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } arss_sync_t;

    localparam arss_sync_t SYNC_RST = 4'h0;
endpackage

// >>> arss_read_seq.sv
// Read-cycle sequencer for an external asynchronous memory, select-strobe mode
`timescale 1ns/1ps
`default_nettype none
module arss_read_seq (
    input wire logic clk,
    input wire logic reset,
    input wire arss_pkg::arss_cfg_t cfg,
    input wire logic rd_req,
    input wire arss_pkg::arss_req_t req,
    input wire logic write_done,
    input wire logic wait_input,
    input wire logic [arss_pkg::DATA_W-1:0] read_value_lines,
    output logic write_strobe_n,
    output logic [arss_pkg::BANKS-1:0] chip_select_n,
    output logic output_enable_n,
    output logic [arss_pkg::ADDR_W-1:0] ext_addr_lines,
    output logic [arss_pkg::BA_W-1:0] low_order_addr_lines,
    output logic [arss_pkg::BE_W-1:0] byte_enable_n,
    output logic addr_valid,
    output arss_pkg::arss_rsp_t rsp,
    output logic busy
);
    arss_pkg::arss_state_t s_r;
    arss_pkg::arss_state_t s_nxt;
    logic wait_level;
    logic wait_act;
    logic [arss_pkg::TA_W-1:0] turn_now;

    // Wait pin comes from the memory's domain, so it is filtered first
    arss_pin_sync wait_sync (
        .clk(clk),
        .reset(reset),
        .pin(wait_input),
        .level(wait_level)
    );

    // Active-low select for one bank
    function automatic arss_pkg::arss_cs_t cs_sel(input logic [arss_pkg::BANK_W-1:0] bank);
        return ~(arss_pkg::CS_ONE << bank);
    endfunction

    // Turnaround length; a preceding read wins over a preceding write
    function automatic logic [arss_pkg::TA_W-1:0] turn_cycles(
        input logic prev_read,
        input logic prev_write,
        input logic [arss_pkg::TA_W-1:0] ta
    );
        if (prev_read) begin
            return arss_pkg::TA_NONE;
        end else if (prev_write && ta == arss_pkg::TA_NONE) begin
            return arss_pkg::TA_AFTER_WR_MIN;
        end
        return ta;
    endfunction

    // First setup of a request: timing, address and enables taken here
    function automatic arss_pkg::arss_state_t enter_setup(
        input arss_pkg::arss_state_t s,
        input arss_pkg::arss_req_t rq,
        input arss_pkg::arss_cfg_t c
    );
        arss_pkg::arss_state_t n;
        n = s;
        n.st = arss_pkg::ST_SETUP;
        n.req = rq;
        n.tim.setup = c.r_setup;
        n.tim.strobe = c.r_strobe;
        n.tim.hold = c.r_hold;
        n.ss = c.ss;
        n.idx = '0;
        n.cnt = arss_pkg::arss_cnt_t'(c.r_setup);
        n.addr_valid = 1'b1;
        n.addr = rq.addr;
        n.ba = rq.ba;
        n.be_n = ~rq.be;
        // Normal mode keeps the select low for the whole access
        n.cs_n = c.ss ? arss_pkg::CS_IDLE : cs_sel(rq.bank);
        n.rsp.start = 1'b1;
        return n;
    endfunction

    assign wait_act = s_r.ss ? (cfg.wait_en && wait_level) : 1'b0;
    assign turn_now = turn_cycles(s_r.prev_read, s_r.prev_write, cfg.turnaround_cycles);

    // Sequencer: idle, turnaround, setup, strobe, hold
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.valid = 1'b0;
        s_nxt.rsp.start = 1'b0;
        s_nxt.rsp.done = 1'b0;
        s_nxt.rsp.abort = 1'b0;
        if (write_done) begin
            s_nxt.prev_write = 1'b1;
            s_nxt.prev_read = 1'b0;
        end
        unique case (s_r.st)
            arss_pkg::ST_IDLE: begin
                if (rd_req) begin
                    s_nxt.turn_len = turn_now;
                    if (turn_now == arss_pkg::TA_NONE) begin
                        s_nxt = enter_setup(s_nxt, req, cfg);
                    end else begin
                        s_nxt.st = arss_pkg::ST_TURN;
                        s_nxt.cnt = arss_pkg::arss_cnt_t'(turn_now - arss_pkg::TA_AFTER_WR_MIN);
                    end
                end
            end
            arss_pkg::ST_TURN: begin
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 6'h1;
                end else if (rd_req) begin
                    s_nxt = enter_setup(s_nxt, req, cfg);
                end else begin
                    // Lost priority while turning round: give the bus back
                    s_nxt.st = arss_pkg::ST_IDLE;
                    s_nxt.rsp.abort = 1'b1;
                end
            end
            arss_pkg::ST_SETUP: begin
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 6'h1;
                end else begin
                    s_nxt.st = arss_pkg::ST_STROBE;
                    s_nxt.cnt = arss_pkg::arss_cnt_t'(s_r.tim.strobe);
                    s_nxt.cs_n = cs_sel(s_r.req.bank);
                    s_nxt.oe_n = 1'b0;
                end
            end
            arss_pkg::ST_STROBE: begin
                // Wait only stretches once the programmed strobe is used up
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 6'h1;
                end else if (!wait_act) begin
                    s_nxt.st = arss_pkg::ST_HOLD;
                    s_nxt.cnt = arss_pkg::arss_cnt_t'(s_r.tim.hold);
                    s_nxt.oe_n = 1'b1;
                    s_nxt.cs_n = s_r.ss ? arss_pkg::CS_IDLE : s_r.cs_n;
                    s_nxt.rsp.data = read_value_lines;
                    s_nxt.rsp.valid = 1'b1;
                end
            end
            arss_pkg::ST_HOLD: begin
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 6'h1;
                end else if (s_r.idx != s_r.req.last_idx) begin
                    // Next narrow access reuses the latched timing
                    s_nxt.st = arss_pkg::ST_SETUP;
                    s_nxt.cnt = arss_pkg::arss_cnt_t'(s_r.tim.setup);
                    s_nxt.idx = s_r.idx + 2'h1;
                    s_nxt.ba = s_r.ba + 2'h1;
                end else begin
                    s_nxt.st = arss_pkg::ST_IDLE;
                    s_nxt.addr_valid = 1'b0;
                    s_nxt.addr = arss_pkg::ADDR_IDLE;
                    s_nxt.ba = arss_pkg::BA_IDLE;
                    s_nxt.be_n = arss_pkg::BE_IDLE_N;
                    s_nxt.cs_n = arss_pkg::CS_IDLE;
                    s_nxt.rsp.done = 1'b1;
                    s_nxt.prev_read = 1'b1;
                    s_nxt.prev_write = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= arss_pkg::STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pins and answer straight from the state register; write strobe tied high
    assign write_strobe_n = 1'b1;
    assign chip_select_n = s_r.cs_n;
    assign output_enable_n = s_r.oe_n;
    assign ext_addr_lines = s_r.addr;
    assign low_order_addr_lines = s_r.ba;
    assign byte_enable_n = s_r.be_n;
    assign addr_valid = s_r.addr_valid;
    assign rsp = s_r.rsp;
    assign busy = (s_r.st != arss_pkg::ST_IDLE);

    // Checking helpers: cycles spent in the current phase, accesses of a request
    arss_pkg::arss_phase_t phase_r;
    logic [arss_pkg::IDX_W:0] acc_r;
    logic leaving;
    assign leaving = (s_nxt.st != s_r.st) || (s_r.st == arss_pkg::ST_HOLD && s_nxt.st == arss_pkg::ST_SETUP);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= '0;
            acc_r <= '0;
        end else begin
            if (leaving) begin
                phase_r <= '0;
            end else if (phase_r != arss_pkg::PHASE_MAX) begin
                phase_r <= phase_r + 8'h1;
            end
            if (s_nxt.rsp.start) begin
                acc_r <= '0;
            end else if (s_nxt.rsp.valid) begin
                acc_r <= acc_r + 3'h1;
            end
        end
    end

    a_we_high: assert property (
        @(posedge clk) disable iff (reset) write_strobe_n == 1'b1)
        else $error("write strobe fell during read");

    a_start_on_prio: assert property (
        @(posedge clk) disable iff (reset) rsp.start |-> $past(rd_req))
        else $error("read started without priority");

    a_all_accesses: assert property (
        @(posedge clk) disable iff (reset)
        rsp.done |-> (acc_r == {1'b0, s_r.req.last_idx} + 3'h1))
        else $error("request ended with wrong access count");

    a_turn_length: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_TURN && s_nxt.st != arss_pkg::ST_TURN)
        |-> (phase_r == arss_pkg::arss_phase_t'(s_r.turn_len) - 8'h1))
        else $error("turnaround length wrong");

    a_no_turn_rd: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_IDLE && rd_req && s_r.prev_read && !write_done)
        |=> s_r.st == arss_pkg::ST_SETUP)
        else $error("turnaround inserted after read");

    a_one_turn_wr: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_IDLE && rd_req && !s_r.prev_read && s_r.prev_write
            && cfg.turnaround_cycles == arss_pkg::TA_NONE)
        |=> s_r.st == arss_pkg::ST_TURN ##1 s_r.st != arss_pkg::ST_TURN)
        else $error("no single turnaround after write");

    a_abandon: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_TURN && s_r.cnt == '0 && !rd_req)
        |=> s_r.st == arss_pkg::ST_IDLE && rsp.abort && addr_valid == 1'b0)
        else $error("read not abandoned");

    a_setup_len: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_SETUP && s_nxt.st == arss_pkg::ST_STROBE)
        |-> phase_r == arss_pkg::arss_phase_t'(s_r.tim.setup))
        else $error("setup length wrong");

    a_addr_held: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st inside {arss_pkg::ST_SETUP, arss_pkg::ST_STROBE, arss_pkg::ST_HOLD})
        |-> addr_valid && ext_addr_lines == s_r.req.addr && byte_enable_n == ~s_r.req.be)
        else $error("address or enables not valid");

    a_cs_strobe: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.ss && s_r.st != arss_pkg::ST_IDLE && s_r.st != arss_pkg::ST_TURN)
        |-> (s_r.st == arss_pkg::ST_STROBE) == (chip_select_n != arss_pkg::CS_IDLE
            && output_enable_n == 1'b0))
        else $error("select not confined to strobe");

    a_capture: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_STROBE && s_nxt.st == arss_pkg::ST_HOLD)
        |=> rsp.valid && output_enable_n && rsp.data == $past(read_value_lines))
        else $error("data not captured at strobe end");

    a_hold_len: assert property (
        @(posedge clk) disable iff (reset)
        (s_r.st == arss_pkg::ST_HOLD && s_nxt.st != arss_pkg::ST_HOLD)
        |-> phase_r == arss_pkg::arss_phase_t'(s_r.tim.hold))
        else $error("hold length wrong");

    c_turn_abort: cover property (@(posedge clk) disable iff (reset) rsp.abort);
    c_wait_stretch: cover property (@(posedge clk) disable iff (reset)
        s_r.st == arss_pkg::ST_STROBE && s_r.cnt == '0 && wait_act);
    c_multi_access: cover property (@(posedge clk) disable iff (reset)
        rsp.done && s_r.req.last_idx != '0);
    c_back_to_back: cover property (@(posedge clk) disable iff (reset)
        rsp.done ##1 rsp.start);
endmodule
`default_nettype wire

// >>> arss_read_seq_test.sv
// Self-checking bench of the select-strobe read sequencer against a cycle model
`timescale 1ns/1ps
`default_nettype none
module arss_read_seq_test;
    logic clk;
    logic reset;
    arss_pkg::arss_cfg_t cfg;
    logic rd_req;
    arss_pkg::arss_req_t req;
    logic write_done;
    logic slow;
    logic wait_input;
    logic [arss_pkg::DATA_W-1:0] read_value_lines;
    logic write_strobe_n;
    logic [arss_pkg::BANKS-1:0] chip_select_n;
    logic output_enable_n;
    logic [arss_pkg::ADDR_W-1:0] ext_addr_lines;
    logic [arss_pkg::BA_W-1:0] low_order_addr_lines;
    logic [arss_pkg::BE_W-1:0] byte_enable_n;
    logic addr_valid;
    arss_pkg::arss_rsp_t rsp;
    logic busy;
    logic [31:0] rnd;
    int n_mismatch;
    int checks;
    int prev_op; // 0 none, 1 read, 2 write

    arss_read_seq u_arss_read_seq (.clk(clk), .reset(reset), .cfg(cfg), .rd_req(rd_req),
        .req(req), .write_done(write_done), .wait_input(wait_input),
        .read_value_lines(read_value_lines), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .ext_addr_lines(ext_addr_lines), .low_order_addr_lines(low_order_addr_lines),
        .byte_enable_n(byte_enable_n), .addr_valid(addr_valid), .rsp(rsp), .busy(busy));

    arss_mem_model u_arss_mem_model (.clk(clk), .reset(reset), .slow(slow),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .ext_addr_lines(ext_addr_lines), .low_order_addr_lines(low_order_addr_lines),
        .read_value_lines(read_value_lines), .wait_input(wait_input));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Memory contents as the attached device holds them
    function automatic logic [15:0] mem_word(input logic [21:0] a, input logic [1:0] b);
        return {a[13:0], b} ^ 16'hA5C3;
    endfunction

    function automatic arss_pkg::arss_cfg_t mk_cfg(input logic [31:0] ta, su, st, ho);
        arss_pkg::arss_cfg_t c;
        c.ss = 1'b1;
        c.wait_en = 1'b1;
        c.turnaround_cycles = ta[1:0];
        c.r_setup = su[3:0];
        c.r_strobe = st[5:0];
        c.r_hold = ho[2:0];
        return c;
    endfunction

    // x packs ba, bank, byte enables and access count minus one, two bits each
    function automatic arss_pkg::arss_req_t mk_req(input logic [31:0] a, input logic [31:0] x);
        arss_pkg::arss_req_t r;
        r.addr = a[21:0];
        r.ba = x[1:0];
        r.bank = x[3:2];
        r.be = x[5:4];
        r.last_idx = x[7:6];
        return r;
    endfunction

    task automatic pulse_write();
        @(posedge clk) write_done <= 1'b1;
        @(posedge clk) write_done <= 1'b0;
        prev_op = 2;
    endtask

    // One request; mode 1 withdraws it, mode 2 alters the strobe field mid-request,
    // mode 3 runs normal mode, mode 4 clears the wait enable
    task automatic run_read(input arss_pkg::arss_req_t r, input arss_pkg::arss_cfg_t c,
                            input int mode, input string name);
        int t, i, acc, ph, n_su, n_st, n_ho, started;
        logic [1:0] ba_k;
        logic [3:0] sel, cs_off;
        bit fin, lower, mix, stretch;
        t = (prev_op == 1) ? 0 : (prev_op == 2 && c.turnaround_cycles == 0) ? 1
            : int'(c.turnaround_cycles);
        {acc, ph, n_su, n_st, n_ho, started, fin} = '0;
        ba_k = r.ba;
        sel = 4'(~(4'h1 << r.bank));
        if (mode == 3) c.ss = 1'b0;
        if (mode == 4) c.wait_en = 1'b0;
        @(posedge clk);
        cfg <= c;
        req <= r;
        rd_req <= 1'b1;
        // Sampled after the edge, so a slow setting made just before is seen
        stretch = slow && c.wait_en;
        for (i = 0; i < 800 && !fin; i++) begin
            @(negedge clk);
            chk_val("write strobe", 1, write_strobe_n);
            if (rsp.start) begin
                chk_cnt("start cycle", t + 1, i);
                started++;
            end
            if (rsp.abort) begin
                chk_cnt("abort cycle", t + 1, i);
                fin = 1;
            end
            if (!output_enable_n) begin
                if (ph == 0) chk_cnt("setup cycles", c.r_setup + 1, n_su);
                ph = 1;
                n_st++;
                chk_val("select", sel, chip_select_n);
            end else begin
                // Normal mode keeps the bank selected from setup through hold
                cs_off = (c.ss || !addr_valid) ? 4'hF : sel;
                chk_val("idle select", cs_off, chip_select_n);
                if (addr_valid && ph == 1) begin
                    ph = 2;
                    n_ho = 0;
                end
                if (addr_valid && ph == 2 && low_order_addr_lines !== ba_k) begin
                    chk_cnt("hold cycles", c.r_hold + 1, n_ho);
                    ba_k++;
                    acc++;
                    {ph, n_su, n_st} = '0;
                end
                if (addr_valid && ph == 0) n_su++;
                if (addr_valid && ph == 2) n_ho++;
            end
            if (addr_valid) begin
                chk_val("address", r.addr, ext_addr_lines);
                chk_val("bank address", ba_k, low_order_addr_lines);
                chk_val("byte enables", 2'(~r.be), byte_enable_n);
            end
            if (rsp.valid) begin
                chk_val("read data", mem_word(r.addr, ba_k), rsp.data);
                if (stretch) chk_cnt("stretch", 1, int'(n_st > c.r_strobe + 1));
                else chk_cnt("strobe cycles", c.r_strobe + 1, n_st);
            end
            if (rsp.done) begin
                chk_cnt("hold cycles", c.r_hold + 1, n_ho);
                chk_cnt("accesses", r.last_idx + 1, acc + 1);
                chk_val("release", 0, {addr_valid, busy});
                fin = 1;
            end
            lower = rsp.start || rsp.abort || (mode == 1 && i >= 1);
            mix = rsp.start && mode == 2;
            @(posedge clk);
            if (lower) rd_req <= 1'b0;
            if (mix) cfg.r_strobe <= ~c.r_strobe;
        end
        if (!fin) begin
            n_mismatch++;
            $display("unexpected end of %s: expected finish, seen timeout", name);
            end_sim();
        end
        chk_cnt("start pulses", (mode == 1) ? 0 : 1, started);
        if (mode != 1) prev_op = 1;
        $display("test %s finished", name);
    endtask

    initial begin
        reset = 1'b1;
        cfg = '0;
        rd_req = 1'b0;
        req = '0;
        write_done = 1'b0;
        slow = 1'b0;
        n_mismatch = 0;
        checks = 0;
        prev_op = 0;
        rnd = $urandom(32'h79B1AE70);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(negedge clk);
        chk_val("idle", 6'h1F, {busy, chip_select_n, output_enable_n});
        run_read(mk_req(32'h12345, 32'h39), mk_cfg(2, 1, 2, 1), 0, "first read");
        run_read(mk_req(32'h2ABCD, 32'hF2), mk_cfg(3, 2, 1, 0), 2, "back to back");
        pulse_write();
        run_read(mk_req(32'h3F00F, 32'h5D), mk_cfg(0, 0, 0, 0), 0, "after write");
        pulse_write();
        run_read(mk_req(32'h00777, 32'h14), mk_cfg(3, 1, 1, 1), 1, "withdrawn");
        pulse_write();
        run_read(mk_req(32'h3FFFF, 32'h6B), mk_cfg(1, 15, 63, 7), 0, "longest");
        // Strobe must outlast the wait synchroniser latency for a stretch to show
        slow <= 1'b1;
        run_read(mk_req(32'h01234, 32'h66), mk_cfg(1, 1, 5, 1), 0, "stretched");
        run_read(mk_req(32'h05678, 32'h24), mk_cfg(1, 1, 5, 1), 4, "wait ignored");
        slow <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            if ($urandom % 2) pulse_write();
            rnd = $urandom | 32'h10;
            run_read(mk_req($urandom, rnd), mk_cfg($urandom, $urandom % 6, $urandom % 8,
                     $urandom), ($urandom % 4 == 0) ? 3 : 0, "random");
        end
        end_sim();
    end
endmodule
`default_nettype wire
